// *** rtl/cpr_pkg.sv ***
// Package: offsets, reset values, codes and frame constants of the clock/power config bank
package cpr_pkg;

  // Serial frame layout: one read/write bit, address, then one data byte
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned DATA_W     = 8;
  localparam logic [4:0]  HDR_LAST   = 5'h0F;   // Count value of the sixteenth header bit
  localparam logic [4:0]  DATA_LAST  = 5'h07;   // Count value of the eighth data bit

  // Register offsets
  localparam logic [14:0] OFS_POWER_MODE_SELECT = 15'h0037;
  localparam logic [14:0] OFS_TIMESTAMP_CTRL    = 15'h003B;
  localparam logic [14:0] OFS_REF_OUTPUT_CTRL   = 15'h003C;
  localparam logic [14:0] OFS_SYNTH_FB_DIV_CTRL = 15'h003D;

  // Values after reset, and the value read back from unmapped offsets
  localparam logic [7:0]  RST_POWER_MODE_SELECT = 8'h4B;
  localparam logic [7:0]  RST_TIMESTAMP_CTRL    = 8'h00;
  localparam logic [7:0]  RST_REF_OUTPUT_CTRL   = 8'h01;
  localparam logic [7:0]  RST_SYNTH_FB_DIV_CTRL = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ         = 8'h00;

  // Power mode codes
  localparam logic [7:0]  PM_LOW_POWER = 8'h46;
  localparam logic [7:0]  PM_HIGH_PERF = 8'h4B;

  // Field positions
  localparam int unsigned TS_RECV_EN_BIT = 0;
  localparam int unsigned TS_PECL_BIT    = 1;
  localparam int unsigned REF_OUT_EN_BIT = 0;
  localparam int unsigned FIRST_DIV_LSB  = 0;
  localparam int unsigned SECOND_DIV_LSB = 2;

  // Frame sequencer states
  typedef enum logic [3:0] {
    CPR_IDLE = 4'b0001,
    CPR_HDR  = 4'b0010,
    CPR_DATA = 4'b0100,
    CPR_DONE = 4'b1000
  } cpr_frame_t;

  // First divider ratio; zero marks the reserved code and stops the chain
  function automatic logic [2:0] cpr_first_ratio(input logic [1:0] code);
    case (code)
      2'h0:    cpr_first_ratio = 3'h5;
      2'h1:    cpr_first_ratio = 3'h4;
      2'h2:    cpr_first_ratio = 3'h3;
      default: cpr_first_ratio = 3'h0;
    endcase
  endfunction

  // Second divider ratio; zero marks the reserved code
  function automatic logic [2:0] cpr_second_ratio(input logic [1:0] code);
    case (code)
      2'h0:    cpr_second_ratio = 3'h1;
      2'h1:    cpr_second_ratio = 3'h2;
      2'h2:    cpr_second_ratio = 3'h4;
      default: cpr_second_ratio = 3'h0;
    endcase
  endfunction

endpackage

// *** rtl/cpr_links.sv ***
// Interfaces between the config bank and its serial front end and divider chain
interface cpr_ser_if;
  logic sel;
  logic bit_in;
  logic rise;
  logic fall;
  modport front (output sel, output bit_in, output rise, output fall);
  modport core  (input sel, input bit_in, input rise, input fall);
endinterface

interface cpr_div_if;
  logic [1:0] first_code;
  logic [1:0] second_code;
  logic       hold;
  logic       first_tick;
  logic       second_tick;
  modport ctrl (output first_code, output second_code, output hold, input first_tick, input second_tick);
  modport div  (input first_code, input second_code, input hold, output first_tick, output second_tick);
endinterface

// *** rtl/cpr_serial_front.sv ***
// Serial port front end: samples pins, makes clock edge strobes
module cpr_serial_front (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic sclk,
  input  wire logic sen_n,
  input  wire logic sdi,
  cpr_ser_if.front  ser
);
  typedef struct packed {
    logic sclk_q;
    logic sel;
    logic bit_in;
    logic rise;
    logic fall;
  } cpr_front_t;

  cpr_front_t q;
  cpr_front_t next_q;

  // Edges are found against the last sample so each strobe lasts one cycle
  always_comb begin
    next_q        = q;
    next_q.sclk_q = sclk;
    next_q.sel    = ~sen_n;
    next_q.bit_in = sdi;
    next_q.rise   = sclk & ~q.sclk_q;
    next_q.fall   = ~sclk & q.sclk_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ser.sel    = q.sel;
  assign ser.bit_in = q.bit_in;
  assign ser.rise   = q.rise;
  assign ser.fall   = q.fall;
endmodule

// *** rtl/cpr_fb_divider.sv ***
// Synthesizer feedback chain: first divider feeding the second
module cpr_fb_divider
  import cpr_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  cpr_div_if.div    dv
);
  typedef struct packed {
    logic [2:0] first_cnt;
    logic [2:0] second_cnt;
    logic       first_tick;
    logic       second_tick;
  } cpr_div_t;

  cpr_div_t   q;
  cpr_div_t   next_q;
  logic [2:0] first_ratio;
  logic [2:0] second_ratio;

  assign first_ratio  = cpr_first_ratio(dv.first_code);
  assign second_ratio = cpr_second_ratio(dv.second_code);

  // Synth reset or a reserved code parks both counters, no ticks
  always_comb begin
    next_q             = q;
    next_q.first_tick  = 1'b0;
    next_q.second_tick = 1'b0;
    if (dv.hold || first_ratio == 3'h0 || second_ratio == 3'h0) begin
      next_q.first_cnt  = 3'h0;
      next_q.second_cnt = 3'h0;
    end else if (q.first_cnt == first_ratio - 3'h1) begin
      next_q.first_cnt  = 3'h0;
      next_q.first_tick = 1'b1;
      // First stage output is the only input of the second
      if (q.second_cnt == second_ratio - 3'h1) begin
        next_q.second_cnt  = 3'h0;
        next_q.second_tick = 1'b1;
      end else begin
        next_q.second_cnt = q.second_cnt + 3'h1;
      end
    end else begin
      next_q.first_cnt = q.first_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign dv.first_tick  = q.first_tick;
  assign dv.second_tick = q.second_tick;
endmodule

// *** rtl/cpr_config_regs.sv ***
// Clock and power configuration register bank behind the serial control port
module cpr_config_regs
  import cpr_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic sclk,
  input  wire logic sen_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  input  wire logic synth_enable,
  input  wire logic synth_reset,
  output logic      power_mode_low,
  output logic      power_mode_high,
  output logic      power_mode_reserved,
  output logic      timestamp_input_enable,
  output logic      timestamp_pecl_termination,
  output logic      synth_ref_clock_output_en,
  output logic      first_div_reserved,
  output logic      second_div_reserved,
  output logic      fb_div_tick,
  output logic      sample_clk_tick
);
  typedef struct packed {
    cpr_frame_t  st;
    logic [4:0]  cnt;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  dbuf;
    logic        sdo;
    logic        sdo_oe;
    logic [7:0]  power_mode_select_reg;
    logic [7:0]  timestamp_input_ctrl;
    logic [7:0]  ref_output_ctrl;
    logic [7:0]  synth_feedback_div_ctrl;
    logic        pm_low;
    logic        pm_high;
    logic        pm_rsvd;
    logic        ts_en;
    logic        ts_pecl;
    logic        ref_en;
    logic        first_rsvd;
    logic        second_rsvd;
    logic        fb_tick;
    logic        smp_tick;
  } cpr_regs_t;

  localparam cpr_regs_t RESET_STATE = '{
    st:                      CPR_IDLE,
    cnt:                     5'h00,
    rd:                      1'b0,
    addr:                    15'h0000,
    dbuf:                    8'h00,
    sdo:                     1'b0,
    sdo_oe:                  1'b0,
    power_mode_select_reg:   RST_POWER_MODE_SELECT,
    timestamp_input_ctrl:    RST_TIMESTAMP_CTRL,
    ref_output_ctrl:         RST_REF_OUTPUT_CTRL,
    synth_feedback_div_ctrl: RST_SYNTH_FB_DIV_CTRL,
    pm_low:                  1'b0,
    pm_high:                 1'b1,
    pm_rsvd:                 1'b0,
    ts_en:                   1'b0,
    ts_pecl:                 1'b0,
    ref_en:                  1'b0,
    first_rsvd:              1'b0,
    second_rsvd:             1'b0,
    fb_tick:                 1'b0,
    smp_tick:                1'b0
  };

  cpr_regs_t  q;
  cpr_regs_t  next_q;
  logic [7:0] rdata;
  logic [7:0] wdata;

  cpr_ser_if ser ();
  cpr_div_if dv ();

  // Pin sampling and edge strobes
  cpr_serial_front u_front (
    .clk   (clk),
    .srst  (srst),
    .sclk  (sclk),
    .sen_n (sen_n),
    .sdi   (sdi),
    .ser   (ser)
  );

  // Feedback divider chain, parked while synth reset is held
  cpr_fb_divider u_div (
    .clk  (clk),
    .srst (srst),
    .dv   (dv)
  );

  // Divider codes come straight from the stored register
  assign dv.first_code  = q.synth_feedback_div_ctrl[FIRST_DIV_LSB +: 2];
  assign dv.second_code = q.synth_feedback_div_ctrl[SECOND_DIV_LSB +: 2];
  // Reset pin is the host's lever for safe divider changes
  assign dv.hold        = synth_reset;

  // Byte completed by the eighth data bit
  assign wdata = {q.dbuf[6:0], ser.bit_in};

  // Read mux; unmapped offsets answer zero rather than stale bus data
  always_comb begin
    case (q.addr)
      OFS_POWER_MODE_SELECT: rdata = q.power_mode_select_reg;
      OFS_TIMESTAMP_CTRL:    rdata = q.timestamp_input_ctrl;
      OFS_REF_OUTPUT_CTRL:   rdata = q.ref_output_ctrl;
      OFS_SYNTH_FB_DIV_CTRL: rdata = q.synth_feedback_div_ctrl;
      default:               rdata = UNMAPPED_READ;
    endcase
  end

  // Frame sequencer, register writes and registered decode of the fields
  always_comb begin
    next_q          = q;
    next_q.fb_tick  = dv.first_tick;
    next_q.smp_tick = dv.second_tick;
    if (!ser.sel) begin
      // Deselect aborts any partial frame; a short frame writes nothing
      next_q.st     = CPR_IDLE;
      next_q.cnt    = 5'h00;
      next_q.sdo_oe = 1'b0;
    end else begin
      case (q.st)
        CPR_IDLE: begin
          next_q.st  = CPR_HDR;
          next_q.cnt = 5'h00;
        end
        CPR_HDR: begin
          if (ser.rise) begin
            // First header bit is the read flag, then address MSB first
            if (q.cnt == 5'h00) begin
              next_q.rd = ser.bit_in;
            end else begin
              next_q.addr = {q.addr[13:0], ser.bit_in};
            end
            if (q.cnt == HDR_LAST) begin
              next_q.st  = CPR_DATA;
              next_q.cnt = 5'h00;
            end else begin
              next_q.cnt = q.cnt + 5'h01;
            end
          end
        end
        CPR_DATA: begin
          // Read data leaves on falling edges so the host samples on rising
          if (ser.fall && q.rd) begin
            next_q.sdo    = rdata[3'h7 - q.cnt[2:0]];
            next_q.sdo_oe = 1'b1;
          end
          if (ser.rise) begin
            next_q.dbuf = wdata;
            if (q.cnt == DATA_LAST) begin
              next_q.st = CPR_DONE;
              if (!q.rd) begin
                // Whole byte stored, reserved bits included, so it reads back
                case (q.addr)
                  OFS_POWER_MODE_SELECT: next_q.power_mode_select_reg   = wdata;
                  OFS_TIMESTAMP_CTRL:    next_q.timestamp_input_ctrl    = wdata;
                  OFS_REF_OUTPUT_CTRL:   next_q.ref_output_ctrl         = wdata;
                  OFS_SYNTH_FB_DIV_CTRL: next_q.synth_feedback_div_ctrl = wdata;
                  default:               next_q.dbuf                    = wdata;
                endcase
              end
            end else begin
              next_q.cnt = q.cnt + 5'h01;
            end
          end
        end
        CPR_DONE: begin
          // Extra clocks are ignored; no address auto-increment
          next_q.st = CPR_DONE;
        end
        default: begin
          next_q.st = CPR_IDLE;
        end
      endcase
    end

    // Decoded outputs follow the register in the same edge as a write
    next_q.pm_low      = next_q.power_mode_select_reg == PM_LOW_POWER;
    next_q.pm_high     = next_q.power_mode_select_reg == PM_HIGH_PERF;
    next_q.pm_rsvd     = !next_q.pm_low && !next_q.pm_high;
    next_q.ts_en       = next_q.timestamp_input_ctrl[TS_RECV_EN_BIT];
    next_q.ts_pecl     = next_q.timestamp_input_ctrl[TS_PECL_BIT];
    next_q.ref_en      = next_q.ref_output_ctrl[REF_OUT_EN_BIT] & synth_enable;
    next_q.first_rsvd  = cpr_first_ratio(next_q.synth_feedback_div_ctrl[FIRST_DIV_LSB +: 2]) == 3'h0;
    next_q.second_rsvd = cpr_second_ratio(next_q.synth_feedback_div_ctrl[SECOND_DIV_LSB +: 2]) == 3'h0;
  end

  // Reset loads the documented defaults, reference enable bit set, ref_en output flop clear until the cycle after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RESET_STATE;
    end else begin
      q <= next_q;
    end
  end

  // Every output is a flop of the state record
  assign sdo                        = q.sdo;
  assign sdo_oe                     = q.sdo_oe;
  assign power_mode_low             = q.pm_low;
  assign power_mode_high            = q.pm_high;
  assign power_mode_reserved        = q.pm_rsvd;
  assign timestamp_input_enable     = q.ts_en;
  assign timestamp_pecl_termination = q.ts_pecl;
  assign synth_ref_clock_output_en  = q.ref_en;
  assign first_div_reserved         = q.first_rsvd;
  assign second_div_reserved        = q.second_rsvd;
  assign fb_div_tick                = q.fb_tick;
  assign sample_clk_tick            = q.smp_tick;
endmodule

// *** test/cpr_config_regs_monitor.sv ***
// Checker: port-level relations of the clock/power config bank
module cpr_config_regs_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic sen_n,
  input wire logic sdo_oe,
  input wire logic synth_enable,
  input wire logic synth_reset,
  input wire logic power_mode_low,
  input wire logic power_mode_high,
  input wire logic power_mode_reserved,
  input wire logic timestamp_input_enable,
  input wire logic timestamp_pecl_termination,
  input wire logic synth_ref_clock_output_en,
  input wire logic first_div_reserved,
  input wire logic second_div_reserved,
  input wire logic fb_div_tick,
  input wire logic sample_clk_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Mode decode is exclusive
  mode_onehot_a: assert property ($onehot({power_mode_low, power_mode_high, power_mode_reserved}))
    else $error("power mode decode not one-hot");
  // Reset forces the documented defaults, so no disable here
  reset_values_a: assert property (disable iff (1'b0) srst |=> power_mode_high && !timestamp_input_enable && !sdo_oe)
    else $error("outputs not at defaults during reset");
  ref_gate_a: assert property (!synth_enable |=> !synth_ref_clock_output_en)
    else $error("reference output on without synth enable");
  // Shortest first ratio is three
  fb_spacing_a: assert property (fb_div_tick |=> !fb_div_tick [*2])
    else $error("feedback ticks closer than three cycles");
  first_stop_a: assert property (first_div_reserved [*2] |-> !fb_div_tick && !sample_clk_tick)
    else $error("tick with reserved first divider code");
  second_stop_a: assert property (second_div_reserved [*2] |-> !sample_clk_tick)
    else $error("tick with reserved second divider code");
  chain_feed_a: assert property (sample_clk_tick |-> fb_div_tick || $past(fb_div_tick))
    else $error("sample tick without feedback tick");
  reset_hold_a: assert property (synth_reset [*3] |-> !fb_div_tick && !sample_clk_tick)
    else $error("divider ticks while synth reset held");
  // Settings move only inside a frame
  cfg_stable_a: assert property (sen_n [*4] |-> $stable({timestamp_input_enable, power_mode_low, power_mode_high}))
    else $error("setting changed outside a frame");
  sdo_quiet_a: assert property (sen_n [*4] |-> !sdo_oe)
    else $error("read driver on while deselected");

  cover property (power_mode_low);
  cover property ($rose(sdo_oe));
  cover property (sample_clk_tick && !fb_div_tick);
endmodule

bind cpr_config_regs cpr_config_regs_monitor cpr_config_regs_monitor_i (
  .clk(clk), .srst(srst), .sen_n(sen_n), .sdo_oe(sdo_oe), .synth_enable(synth_enable), .synth_reset(synth_reset),
  .power_mode_low(power_mode_low), .power_mode_high(power_mode_high), .power_mode_reserved(power_mode_reserved),
  .timestamp_input_enable(timestamp_input_enable), .timestamp_pecl_termination(timestamp_pecl_termination),
  .synth_ref_clock_output_en(synth_ref_clock_output_en), .first_div_reserved(first_div_reserved),
  .second_div_reserved(second_div_reserved), .fb_div_tick(fb_div_tick), .sample_clk_tick(sample_clk_tick));

// *** test/cpr_host_model.sv ***
// Host model: drives serial frames into the config bank
module cpr_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      sen_n,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk  = 1'b0;
    sen_n = 1'b1;
    sdi   = 1'b0;
  end

  // One frame; callers pass reserved bits as zero
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    sen_n = 1'b0;
    // Four clk per level keeps clear of the three-cycle minimum
    for (int i = 0; i < 24; i++) begin
      sclk = 1'b0;
      sdi  = f[23-i];
      repeat (4) @(negedge clk);
      if (i >= 16) q[23-i] = sdo;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (4) @(negedge clk);
    sen_n = 1'b1;
    sdi   = ~sdi;
    repeat (4) @(negedge clk);
  endtask
endmodule

// *** test/cpr_config_regs_bench.sv ***
// Testbench for the clock/power config bank
module cpr_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpr_pkg::*;

  logic clk, srst, sclk, sen_n, sdi, sdo, sdo_oe, synth_enable, synth_reset;
  logic pm_low, pm_high, pm_res, ts_en, ts_pecl, ref_en, div1_res, div2_res, fb_tick, smp_tick;
  logic [7:0] q;
  int         mismatches;
  int         cmp_count;
  int         n;
  int         fr [3] = '{5, 4, 3};
  int         sr [3] = '{1, 2, 4};
  logic [7:0] codes [3] = '{8'h46, 8'h00, 8'h4B};

  cpr_host_model cpr_host_model_i (.clk(clk), .sclk(sclk), .sen_n(sen_n), .sdi(sdi), .sdo(sdo));

  cpr_config_regs cpr_config_regs_i (
    .clk(clk), .srst(srst), .sclk(sclk), .sen_n(sen_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .synth_enable(synth_enable), .synth_reset(synth_reset), .power_mode_low(pm_low), .power_mode_high(pm_high),
    .power_mode_reserved(pm_res), .timestamp_input_enable(ts_en), .timestamp_pecl_termination(ts_pecl),
    .synth_ref_clock_output_en(ref_en), .first_div_reserved(div1_res), .second_div_reserved(div2_res),
    .fb_div_tick(fb_tick), .sample_clk_tick(smp_tick));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    cpr_host_model_i.xfer(1'b0, a, d, dummy);
  endtask

  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    cpr_host_model_i.xfer(1'b1, a, 8'h00, d);
  endtask

  // Cycles between two ticks; 200 means none came
  task automatic period(input bit second, output int cnt);
    int w;
    w = 0;
    while (((second ? smp_tick : fb_tick) !== 1'b1) && w < 200) begin
      @(negedge clk);
      w++;
    end
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (((second ? smp_tick : fb_tick) !== 1'b1) && cnt < 200);
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Divider change bracketed by synth reset
  task automatic set_div(input logic [7:0] v);
    synth_reset = 1'b1;
    wr(OFS_SYNTH_FB_DIV_CTRL, v);
    synth_reset = 1'b0;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    synth_enable = 1'b1;
    synth_reset = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    rd(OFS_POWER_MODE_SELECT, q); chk("mode reset", q, 8'h4B);
    rd(OFS_TIMESTAMP_CTRL, q); chk("ts reset", q, 8'h00);
    rd(OFS_REF_OUTPUT_CTRL, q); chk("ref reset", q, 8'h01);
    rd(OFS_SYNTH_FB_DIV_CTRL, q); chk("div reset", q, 8'h00);
    chk("ref out unwritten", ref_en, 8'h01);
    chk("ts off", ts_en, 8'h00);
    // Companions and calibration sit outside this bank
    for (int m = 0; m < 3; m++) begin
      wr(OFS_POWER_MODE_SELECT, codes[m]);
      chk("mode decode", {5'h00, pm_low, pm_res, pm_high}, 8'h01 << (2 - m));
      rd(OFS_POWER_MODE_SELECT, q); chk("mode readback", q, codes[m]);
    end
    for (int k = 1; k < 3; k++) begin
      wr(OFS_TIMESTAMP_CTRL, 8'(k));
      chk("ts enable", ts_en, 8'(k & 1));
      chk("ts pecl", ts_pecl, 8'(k >> 1));
    end
    rd(OFS_TIMESTAMP_CTRL, q); chk("ts readback", q, 8'h02);
    synth_enable = 1'b0;
    repeat (3) @(negedge clk);
    chk("ref gated", ref_en, 8'h00);
    synth_enable = 1'b1;
    repeat (3) @(negedge clk);
    chk("ref ungated", ref_en, 8'h01);
    wr(OFS_REF_OUTPUT_CTRL, 8'h00);
    chk("ref disabled", ref_en, 8'h00);
    rd(OFS_REF_OUTPUT_CTRL, q); chk("ref readback", q, 8'h00);
    chk("read driver off", sdo_oe, 8'h00);
    wr(OFS_REF_OUTPUT_CTRL, 8'h01);
    // Every legal pair of divider codes
    for (int f = 0; f < 3; f++) begin
      for (int s = 0; s < 3; s++) begin
        set_div(8'((s << 2) | f));
        period(1'b0, n); chk("fb period", 8'(n), 8'(fr[f]));
        period(1'b1, n); chk("sample period", 8'(n), 8'(fr[f] * sr[s]));
      end
    end
    set_div(8'h03);
    chk("first reserved", div1_res, 8'h01);
    period(1'b0, n); chk("first stopped", 8'(n), 8'd200);
    set_div(8'h0C);
    chk("second reserved", div2_res, 8'h01);
    period(1'b1, n); chk("second stopped", 8'(n), 8'd200);
    rd(OFS_SYNTH_FB_DIV_CTRL, q); chk("div readback", q, 8'h0C);
    wr(15'h0038, 8'h5A);
    rd(15'h0038, q); chk("unmapped", q, 8'h00);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rd(OFS_POWER_MODE_SELECT, q); chk("mode after reset", q, 8'h4B);
    chk("ref after reset", ref_en, 8'h01);
    give_verdict();
  end
endmodule
